/* File: verilog/arsm_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE1: Three relay outputs each follow one of 32 conditions coded 1..32.
// RULE2: After reset the selectors hold run/stop, at-speed/stop and any-trip.
// RULE3: Codes 1-4 show run, at-speed, at-speed to decel end, start to decel end.
// RULE4: Codes 5-21 each show one specific protection trip.
// RULE5: Code 22 shows any trip steadily, code 23 flashes it half a second on/off.
// RULE6: Codes 24-27 show coast-down, starts-per-hour, between-starts, any lockout.
// RULE7: Codes 28-31 repeat codes 1-4 behind the shared on-delay.
// RULE8: The on-delay takes 1-999 seconds, 0 disables it, and it resets to 0.
// RULE9: Code 32 shows a trip on loss of control power.
// RULE10: A delayed relay turns on after the full delay and off at once.
module arsm_top #(
   parameter int HALF_SEC_CYCLES = arsm_pkg::FLASH_HALF_CYCLES
) (
   input  wire logic                           aclk,
   input  wire logic                           aresetn,
   input  wire logic [arsm_pkg::ADDR_W-1:0]    s_axi_awaddr,
   input  wire logic                           s_axi_awvalid,
   output logic                                s_axi_awready,
   input  wire logic [31:0]                    s_axi_wdata,
   input  wire logic [3:0]                     s_axi_wstrb,
   input  wire logic                           s_axi_wvalid,
   output logic                                s_axi_wready,
   output logic [1:0]                          s_axi_bresp,
   output logic                                s_axi_bvalid,
   input  wire logic                           s_axi_bready,
   input  wire logic [arsm_pkg::ADDR_W-1:0]    s_axi_araddr,
   input  wire logic                           s_axi_arvalid,
   output logic                                s_axi_arready,
   output logic [31:0]                         s_axi_rdata,
   output logic [1:0]                          s_axi_rresp,
   output logic                                s_axi_rvalid,
   input  wire logic                           s_axi_rready,
   input  wire logic                           motor_running,
   input  wire logic                           motor_at_speed,
   input  wire logic                           motor_decel,
   input  wire logic [arsm_pkg::NUM_TRIPS-1:0] trip_flags,
   input  wire logic [arsm_pkg::NUM_LOCKOUTS-1:0] lockout_flags,
   input  wire logic                           control_power_lost,
   output logic [arsm_pkg::NUM_RELAYS-1:0]     relay_out,
   output logic                                irq
);

   localparam int CNT_W = $clog2(HALF_SEC_CYCLES);

   logic [arsm_pkg::SEL_W-1:0]      relay_sel [arsm_pkg::NUM_RELAYS];
   logic [arsm_pkg::DELAY_W-1:0]    relay_on_delay_seconds;
   logic [arsm_pkg::NUM_RELAYS-1:0] irq_status;
   logic [arsm_pkg::NUM_RELAYS-1:0] irq_mask;
   logic [arsm_pkg::NUM_RELAYS-1:0] relay_event;
   logic [arsm_pkg::NUM_RELAYS-1:0] next_relay;
   logic [arsm_pkg::NUM_RELAYS-1:0] sel_level;
   logic [arsm_pkg::NUM_RELAYS-1:0] sel_delayed;
   logic [arsm_pkg::NUM_COND-1:0]   cond_vec;
   logic [CNT_W-1:0]                half_cnt;
   logic                            half_tick;
   logic                            sec_tick;
   logic                            flash_phase;
   logic                            any_trip;
   logic                            any_lock;
   logic                            aw_full;
   logic                            w_full;
   logic [arsm_pkg::ADDR_W-1:0]     aw_addr;
   logic [31:0]                     w_data;
   logic [3:0]                      w_strb;
   logic                            wr_fire;
   logic [31:0]                     wr_mask;
   logic [31:0]                     wr_new;

   // ------------------------------------------------------------
   // Register read view
   // ------------------------------------------------------------
   function automatic logic [31:0] reg_value(
      input logic [arsm_pkg::ADDR_W-1:0] addr);
      reg_value = 32'h0000_0000;
      if (addr == arsm_pkg::ADDR_SEL_ONE) begin
         reg_value = 32'(relay_sel[0]);
      end else if (addr == arsm_pkg::ADDR_SEL_TWO) begin
         reg_value = 32'(relay_sel[1]);
      end else if (addr == arsm_pkg::ADDR_SEL_THREE) begin
         reg_value = 32'(relay_sel[2]);
      end else if (addr == arsm_pkg::ADDR_DELAY) begin
         reg_value = 32'(relay_on_delay_seconds);
      end else if (addr == arsm_pkg::ADDR_STATE) begin
         reg_value = 32'({any_lock, any_trip, relay_out});
      end else if (addr == arsm_pkg::ADDR_IRQ_STATUS) begin
         reg_value = 32'(irq_status);
      end else if (addr == arsm_pkg::ADDR_IRQ_MASK) begin
         reg_value = 32'(irq_mask);
      end
   endfunction

   function automatic logic addr_hit(input logic [arsm_pkg::ADDR_W-1:0] addr);
      addr_hit = (addr == arsm_pkg::ADDR_SEL_ONE)
              || (addr == arsm_pkg::ADDR_SEL_TWO)
              || (addr == arsm_pkg::ADDR_SEL_THREE)
              || (addr == arsm_pkg::ADDR_DELAY)
              || (addr == arsm_pkg::ADDR_STATE)
              || (addr == arsm_pkg::ADDR_IRQ_STATUS)
              || (addr == arsm_pkg::ADDR_IRQ_MASK);
   endfunction

   // ------------------------------------------------------------
   // Write channel
   // ------------------------------------------------------------
   // Address and data are parked separately so either may come first.
   assign s_axi_awready = !aw_full && !s_axi_bvalid;
   assign s_axi_wready  = !w_full && !s_axi_bvalid;
   assign wr_fire       = aw_full && w_full && !s_axi_bvalid;

   always_comb begin
      wr_mask = {{8{w_strb[3]}}, {8{w_strb[2]}},
                 {8{w_strb[1]}}, {8{w_strb[0]}}};
      wr_new  = (reg_value(aw_addr) & ~wr_mask) | (w_data & wr_mask);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         aw_addr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_full <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_full <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_full <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_full <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= arsm_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= addr_hit(aw_addr) ? arsm_pkg::RESP_OKAY
                                           : arsm_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Out-of-range settings are dropped so a relay can never lose its
   // condition through a bad write.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         relay_sel[0]           <= arsm_pkg::RST_SEL_ONE; // RULE2
         relay_sel[1]           <= arsm_pkg::RST_SEL_TWO; // RULE2
         relay_sel[2]           <= arsm_pkg::RST_SEL_THREE; // RULE2
         relay_on_delay_seconds <= arsm_pkg::RST_DELAY; // RULE8
      end else if (wr_fire) begin
         if (wr_new >= 32'(arsm_pkg::SEL_MIN) &&
             wr_new <= 32'(arsm_pkg::SEL_MAX)) begin
            if (aw_addr == arsm_pkg::ADDR_SEL_ONE) begin
               relay_sel[0] <= wr_new[arsm_pkg::SEL_W-1:0]; // RULE1
            end else if (aw_addr == arsm_pkg::ADDR_SEL_TWO) begin
               relay_sel[1] <= wr_new[arsm_pkg::SEL_W-1:0]; // RULE1
            end else if (aw_addr == arsm_pkg::ADDR_SEL_THREE) begin
               relay_sel[2] <= wr_new[arsm_pkg::SEL_W-1:0]; // RULE1
            end
         end
         if (aw_addr == arsm_pkg::ADDR_DELAY &&
             wr_new <= 32'(arsm_pkg::DELAY_MAX)) begin
            relay_on_delay_seconds <= wr_new[arsm_pkg::DELAY_W-1:0]; // RULE8
         end
      end
   end

   // ------------------------------------------------------------
   // Read channel
   // ------------------------------------------------------------
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= arsm_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= reg_value(s_axi_araddr);
         s_axi_rresp  <= addr_hit(s_axi_araddr) ? arsm_pkg::RESP_OKAY
                                                : arsm_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Half-second prescaler and flasher
   // ------------------------------------------------------------
   // The flasher runs free, so the first flash after a trip may be short.
   assign half_tick = (half_cnt == CNT_W'(HALF_SEC_CYCLES - 1));
   assign sec_tick  = half_tick && flash_phase;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         half_cnt    <= '0;
         flash_phase <= 1'b0;
      end else if (half_tick) begin
         half_cnt    <= '0;
         flash_phase <= !flash_phase; // RULE5
      end else begin
         half_cnt    <= half_cnt + 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Condition vector
   // ------------------------------------------------------------
   assign any_trip = |trip_flags;
   assign any_lock = |lockout_flags;

   always_comb begin
      cond_vec = '0;
      cond_vec[arsm_pkg::SEL_RUN]         = motor_running; // RULE3
      cond_vec[arsm_pkg::SEL_AT_SPEED]    = motor_at_speed; // RULE3
      cond_vec[arsm_pkg::SEL_SPEED_DECEL] = motor_at_speed | motor_decel;
      cond_vec[arsm_pkg::SEL_START_DECEL] = motor_running | motor_decel;
      cond_vec[arsm_pkg::SEL_TRIP_LAST:arsm_pkg::SEL_TRIP_FIRST] =
         trip_flags; // RULE4
      cond_vec[arsm_pkg::SEL_ANY_TRIP]    = any_trip; // RULE5
      cond_vec[arsm_pkg::SEL_TRIP_FLASH]  = any_trip & flash_phase; // RULE5
      cond_vec[arsm_pkg::SEL_LOCK_LAST:arsm_pkg::SEL_LOCK_FIRST] =
         lockout_flags; // RULE6
      cond_vec[arsm_pkg::SEL_ANY_LOCK]    = any_lock; // RULE6
      cond_vec[arsm_pkg::SEL_DLY_LAST:arsm_pkg::SEL_DLY_FIRST] =
         cond_vec[arsm_pkg::SEL_START_DECEL:arsm_pkg::SEL_RUN]; // RULE7
      cond_vec[arsm_pkg::SEL_CP_LOST]     = control_power_lost; // RULE9
   end

   // ------------------------------------------------------------
   // Relay channels
   // ------------------------------------------------------------
   for (genvar i = 0; i < arsm_pkg::NUM_RELAYS; i++) begin : g_relay
      arsm_cond_select u_select (
         .cond_vec (cond_vec),
         .select   (relay_sel[i]),
         .level    (sel_level[i]),
         .delayed  (sel_delayed[i])
      );
      arsm_on_delay #(
         .DELAY_W (arsm_pkg::DELAY_W)
      ) u_delay (
         .aclk      (aclk),
         .aresetn   (aresetn),
         .sec_tick  (sec_tick),
         .delay_s   (relay_on_delay_seconds),
         .use_delay (sel_delayed[i]),
         .cond      (sel_level[i]),
         .active    (next_relay[i])
      );
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         relay_out <= '0;
      end else begin
         relay_out <= next_relay; // RULE1
      end
   end

   // ------------------------------------------------------------
   // Interrupts
   // ------------------------------------------------------------
   assign relay_event = next_relay ^ relay_out;

   // A change in the same cycle as the clear keeps its bit set.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= '0;
         irq_mask   <= arsm_pkg::RST_IRQ_MASK;
      end else begin
         if (wr_fire && aw_addr == arsm_pkg::ADDR_IRQ_STATUS) begin
            irq_status <= (irq_status &
               ~(w_data[arsm_pkg::NUM_RELAYS-1:0] &
                 wr_mask[arsm_pkg::NUM_RELAYS-1:0])) | relay_event;
         end else begin
            irq_status <= irq_status | relay_event;
         end
         if (wr_fire && aw_addr == arsm_pkg::ADDR_IRQ_MASK) begin
            irq_mask <= wr_new[arsm_pkg::NUM_RELAYS-1:0];
         end
      end
   end

   assign irq = |(irq_status & irq_mask);

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   AST_SEL_RANGE: // RULE1
   assert property (@(posedge aclk) disable iff (!aresetn)
      relay_sel[1] >= arsm_pkg::SEL_MIN && relay_sel[1] <= arsm_pkg::SEL_MAX)
      else $error("Relay selector left the legal range.");

   AST_RESET_DEFAULT: // RULE2
   assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> (relay_sel[0] == arsm_pkg::SEL_RUN &&
         relay_sel[1] == arsm_pkg::SEL_AT_SPEED &&
         relay_sel[2] == arsm_pkg::SEL_ANY_TRIP &&
         relay_on_delay_seconds == '0))
      else $error("Selectors are not at their defaults after reset.");

   AST_RUN_DIRECT: // RULE3
   assert property (@(posedge aclk) disable iff (!aresetn)
      (relay_sel[0] == arsm_pkg::SEL_RUN) |=>
         (relay_out[0] == $past(motor_running)))
      else $error("Run selection did not follow the run flag.");

   AST_TRIP_QUIET: // RULE4
   assert property (@(posedge aclk) disable iff (!aresetn)
      (relay_sel[0] >= arsm_pkg::SEL_TRIP_FIRST &&
       relay_sel[0] <= arsm_pkg::SEL_TRIP_LAST && trip_flags == '0)
         |=> !relay_out[0])
      else $error("Trip selection active with no trip present.");

   AST_FLASH_TOGGLE: // RULE5
   assert property (@(posedge aclk) disable iff (!aresetn)
      1'b1 |=> ((flash_phase ^ $past(flash_phase)) == $past(half_tick)))
      else $error("Flasher changed phase off the half-second tick.");

   AST_ANY_TRIP_STEADY: // RULE5
   assert property (@(posedge aclk) disable iff (!aresetn)
      (relay_sel[2] == arsm_pkg::SEL_ANY_TRIP && any_trip) |=> relay_out[2])
      else $error("Any-trip selection did not hold the relay on.");

   AST_ANY_LOCK: // RULE6
   assert property (@(posedge aclk) disable iff (!aresetn)
      (relay_sel[0] == arsm_pkg::SEL_ANY_LOCK) |=>
         (relay_out[0] == $past(any_lock)))
      else $error("Any-lockout selection did not follow the lockouts.");

   AST_DELAYED_RUN: // RULE7
   assert property (@(posedge aclk) disable iff (!aresetn)
      (relay_sel[1] == arsm_pkg::SEL_DLY_FIRST &&
       relay_on_delay_seconds == '0) |=>
         (relay_out[1] == $past(motor_running)))
      else $error("Delayed run selection with zero delay did not follow.");

   AST_DELAY_RANGE: // RULE8
   assert property (@(posedge aclk) disable iff (!aresetn)
      relay_on_delay_seconds <= arsm_pkg::DELAY_MAX)
      else $error("On-delay setting above its maximum.");

   AST_CP_LOST: // RULE9
   assert property (@(posedge aclk) disable iff (!aresetn)
      (relay_sel[2] == arsm_pkg::SEL_CP_LOST) |=>
         (relay_out[2] == $past(control_power_lost)))
      else $error("Control-power selection did not follow its flag.");

endmodule
`default_nettype wire

/* File: verilog/arsm_pkg.sv */
`default_nettype none
package arsm_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam int          ADDR_W          = 8;
   localparam logic [7:0]  ADDR_SEL_ONE    = 8'h00;
   localparam logic [7:0]  ADDR_SEL_TWO    = 8'h04;
   localparam logic [7:0]  ADDR_SEL_THREE  = 8'h08;
   localparam logic [7:0]  ADDR_DELAY      = 8'h0C;
   localparam logic [7:0]  ADDR_STATE      = 8'h10;
   localparam logic [7:0]  ADDR_IRQ_STATUS = 8'h14;
   localparam logic [7:0]  ADDR_IRQ_MASK   = 8'h18;

   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   // ------------------------------------------------------------
   // Widths and counts
   // ------------------------------------------------------------
   localparam int          NUM_RELAYS      = 3;
   localparam int          NUM_TRIPS       = 17;
   localparam int          NUM_LOCKOUTS    = 3;
   localparam int          NUM_COND        = 33;
   localparam int          SEL_W           = 6;
   localparam int          DELAY_W         = 10;

   // ------------------------------------------------------------
   // Selection codes
   // ------------------------------------------------------------
   localparam logic [5:0]  SEL_MIN         = 6'h01;
   localparam logic [5:0]  SEL_RUN         = 6'h01;
   localparam logic [5:0]  SEL_AT_SPEED    = 6'h02;
   localparam logic [5:0]  SEL_SPEED_DECEL = 6'h03;
   localparam logic [5:0]  SEL_START_DECEL = 6'h04;
   localparam logic [5:0]  SEL_TRIP_FIRST  = 6'h05;
   localparam logic [5:0]  SEL_TRIP_LAST   = 6'h15;
   localparam logic [5:0]  SEL_ANY_TRIP    = 6'h16;
   localparam logic [5:0]  SEL_TRIP_FLASH  = 6'h17;
   localparam logic [5:0]  SEL_LOCK_FIRST  = 6'h18;
   localparam logic [5:0]  SEL_LOCK_LAST   = 6'h1A;
   localparam logic [5:0]  SEL_ANY_LOCK    = 6'h1B;
   localparam logic [5:0]  SEL_DLY_FIRST   = 6'h1C;
   localparam logic [5:0]  SEL_DLY_LAST    = 6'h1F;
   localparam logic [5:0]  SEL_CP_LOST     = 6'h20;
   localparam logic [5:0]  SEL_MAX         = 6'h20;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [5:0]  RST_SEL_ONE     = SEL_RUN;
   localparam logic [5:0]  RST_SEL_TWO     = SEL_AT_SPEED;
   localparam logic [5:0]  RST_SEL_THREE   = SEL_ANY_TRIP;
   localparam logic [9:0]  RST_DELAY       = 10'h000;
   localparam logic [9:0]  DELAY_MAX       = 10'h3E7;
   localparam logic [2:0]  RST_IRQ_MASK    = 3'h0;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int          CLK_FREQ_HZ     = 200_000_000;
   localparam int          FLASH_HALF_MS   = 500;
   localparam int          FLASH_HALF_CYCLES =
      FLASH_HALF_MS * (CLK_FREQ_HZ / 1000);

endpackage
`default_nettype wire

/* File: verilog/arsm_cond_select.sv */
`timescale 1ns/1ps
`default_nettype none
module arsm_cond_select (
   input  wire logic [arsm_pkg::NUM_COND-1:0] cond_vec,
   input  wire logic [arsm_pkg::SEL_W-1:0]    select,
   output logic                               level,
   output logic                               delayed
);

   always_comb begin
      level   = 1'b0;
      delayed = 1'b0;
      if (select >= arsm_pkg::SEL_MIN && select <= arsm_pkg::SEL_MAX) begin
         level = cond_vec[select]; // RULE1
      end
      if (select >= arsm_pkg::SEL_DLY_FIRST &&
          select <= arsm_pkg::SEL_DLY_LAST) begin
         delayed = 1'b1; // RULE7
      end
   end

endmodule
`default_nettype wire

/* File: verilog/arsm_on_delay.sv */
`timescale 1ns/1ps
`default_nettype none
module arsm_on_delay #(
   parameter int DELAY_W = arsm_pkg::DELAY_W
) (
   input  wire logic               aclk,
   input  wire logic               aresetn,
   input  wire logic               sec_tick,
   input  wire logic [DELAY_W-1:0] delay_s,
   input  wire logic               use_delay,
   input  wire logic               cond,
   output logic                    active
);

   logic [DELAY_W-1:0] count;

   // Ticks are counted while the condition holds; one tick more than the
   // setting is needed because the first second may start part-way.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count <= '0;
      end else if (!cond) begin
         count <= '0; // RULE10
      end else if (sec_tick && count != '1) begin
         count <= count + 1'b1;
      end
   end

   assign active = cond &
      (!use_delay || delay_s == '0 || count > delay_s); // RULE10

   AST_OFF_AT_ONCE: // RULE10
   assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(cond) |-> !active)
      else $error("Relay stayed on after its condition ended.");

   AST_NO_EARLY_ON: // RULE10
   assert property (@(posedge aclk) disable iff (!aresetn)
      (use_delay && delay_s != '0 && $rose(cond)) |-> !active [*2])
      else $error("Delayed relay turned on before its delay ran.");

   AST_ZERO_DELAY: // RULE8
   assert property (@(posedge aclk) disable iff (!aresetn)
      (!use_delay || delay_s == '0) |-> (active == cond))
      else $error("Undelayed relay did not follow its condition.");

endmodule
`default_nettype wire

/* File: tb/arsm_relay_load.sv */
`timescale 1ns/1ps
`default_nettype none
// -----
// Load on the relay contacts
// -----
// It only counts contact changes, because the far side cannot answer back.
module arsm_relay_load (
   input  wire logic       aclk,
   input  wire logic [2:0] relay_out,
   output int              flips [3]
);
   logic [2:0] last = 3'h0;
   initial flips = '{0, 0, 0};
   always @(posedge aclk) begin
      for (int i = 0; i < 3; i++) begin
         if (relay_out[i] !== last[i]) begin
            flips[i]++;
         end
      end
      last = relay_out;
   end
endmodule
`default_nettype wire

/* File: tb/arsm_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module arsm_top_tb_top;
   // -----
   // Signals and instances
   // -----
   logic        aclk = 1'b0, aresetn = 1'b0, irq;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [31:0] seed = 32'h000185F4;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, motor_running = 1'b0, motor_at_speed = 1'b0;
   logic motor_decel = 1'b0, control_power_lost = 1'b0;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   logic [16:0] trip_flags = 17'h0;
   logic [2:0]  lockout_flags = 3'h0, relay_out;
   int num_errors = 0, check_count = 0, flips [3], f0;
   always #2.5 aclk = ~aclk;
   arsm_top #(.HALF_SEC_CYCLES(4)) dut (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .motor_running, .motor_at_speed, .motor_decel, .trip_flags,
      .lockout_flags, .control_power_lost, .relay_out, .irq);
   arsm_relay_load load (.aclk, .relay_out, .flips);
   // -----
   // Tasks and model
   // -----
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic bad(input string m);
      num_errors++;
      $display("wrong value at %0t: %s", $time, m);
   endtask
   task automatic must(input logic ok);
      if (!ok) begin
         bad("timeout");
         close_out();
      end
   endtask
   task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) bad("register word");
   endtask
   task automatic chk_relay(input logic g, input logic e);
      check_count++;
      if (g !== e) bad("relay level");
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge aclk);
      @(negedge aclk);
   endtask
   // Ready is sampled at the falling edge; inputs only move at rising ones.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ad = 1'b0, wd = 1'b0, bd = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (int n = 0; n < 40 && !bd; n++) begin
         @(negedge aclk);
         ad |= s_axi_awvalid & s_axi_awready;
         wd |= s_axi_wvalid & s_axi_wready;
         bd = s_axi_bvalid;
         resp = s_axi_bresp;
         @(posedge aclk);
         if (ad) s_axi_awvalid <= 1'b0;
         if (wd) s_axi_wvalid <= 1'b0;
      end
      must(bd);
   endtask
   task automatic rd_reg(input logic [7:0] a);
      logic ad = 1'b0, dd = 1'b0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (int n = 0; n < 40 && !dd; n++) begin
         @(negedge aclk);
         ad |= s_axi_arvalid & s_axi_arready;
         dd = s_axi_rvalid;
         rd = s_axi_rdata;
         resp = s_axi_rresp;
         @(posedge aclk);
         if (ad) s_axi_arvalid <= 1'b0;
      end
      must(dd);
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic model(input int s);
      int b = (s >= 28 && s <= 31) ? s - 27 : s;
      case (b)
         1: return motor_running;
         2: return motor_at_speed;
         3: return motor_at_speed | motor_decel;
         4: return motor_running | motor_decel;
         22: return |trip_flags;
         27: return |lockout_flags;
         32: return control_power_lost;
         default: return (b < 22) ? trip_flags[b-5] : lockout_flags[b-24];
      endcase
   endfunction
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd_reg(8'h00);
      chk_reg(rd, 32'h1);
      rd_reg(8'h04);
      chk_reg(rd, 32'h2);
      rd_reg(8'h08);
      chk_reg(rd, 32'h16);
      rd_reg(8'h0C);
      chk_reg(rd, 32'h0);
      wr(8'h00, 32'h21);
      wr(8'h0C, 32'h3E8);
      rd_reg(8'h00);
      chk_reg(rd, 32'h1);
      rd_reg(8'h0C);
      chk_reg(rd, 32'h0);
      rd_reg(8'h40);
      chk_reg({30'h0, resp}, 32'h2);
      $display("test defaults done");
      wr(8'h18, 32'h1);
      motor_running <= 1'b1;
      settle(3);
      chk_relay(irq, 1'b1);
      @(posedge aclk);
      rd_reg(8'h14);
      chk_reg(rd, 32'h1);
      wr(8'h14, 32'h1);
      wr(8'h18, 32'h0);
      motor_running <= 1'b0;
      settle(3);
      chk_relay(irq, 1'b0);
      @(posedge aclk);
      rd_reg(8'h14);
      chk_reg(rd, 32'h1);
      $display("test interrupt done");
      for (int s = 1; s <= 32; s++) begin
         if (s == 23) continue;
         wr(8'(4 * (s % 3)), 32'(s));
         repeat (4) begin
            seed = lfsr(seed);
            {motor_running, motor_at_speed, motor_decel} <= seed[2:0];
            control_power_lost <= seed[3];
            trip_flags <= seed[20:4] & {17{seed[21]}};
            lockout_flags <= seed[24:22];
            settle(2);
            chk_relay(relay_out[s % 3], model(s));
            @(posedge aclk);
         end
      end
      $display("test selections done");
      wr(8'h08, 32'h17);
      {motor_running, motor_at_speed, motor_decel, control_power_lost} <= 4'h0;
      lockout_flags <= 3'h0;
      trip_flags <= 17'h1;
      settle(3);
      f0 = flips[2];
      settle(32);
      chk_reg(32'(flips[2] - f0), 32'h8);
      @(posedge aclk);
      $display("test flash done");
      wr(8'h0C, 32'h2);
      wr(8'h04, 32'h1D);
      motor_at_speed <= 1'b1;
      settle(15);
      chk_relay(relay_out[1], 1'b0);
      settle(12);
      chk_relay(relay_out[1], 1'b1);
      @(posedge aclk);
      motor_at_speed <= 1'b0;
      settle(2);
      chk_relay(relay_out[1], 1'b0);
      $display("test on delay done");
      close_out();
   end
endmodule
`default_nettype wire
